// ### verilog/agb_ctrl.sv
// Amplifier gain, switch, current buffer and error flag control
//
// Operation
// R1: each input switch opens or closes individually from a host written bit
// R2: four buffer path switches follow buffer active state, not host bits
// R3: chopper clock 250 kHz from internal 1 MHz; external clock selectable
// R4: register 0 byte holds gain code and external multiplexer address
// R5: gain code selects one of eleven binary steps 128 down to 1/8
// R6: gain resets to the one-eighth attenuation code
// R7: output stage factor selectable unity or larger fixed factor
// R8: output stage factor resets to unity
// R9: buffer turns off after duration from register 3 time field
// R10: command byte bit 5 activates the current buffer
// R11: buffer trigger input (general pin 4) also starts the buffer
// R12: buffer active status reads high while buffer is on
// R13: separate flags for overvoltage, amplifier clipping, gain overload
// R14: clamp conduction flag when current entered the input clamp
// R15: output fault flag on output rail clip or overcurrent
// R16: host should start the buffer with each multiplexer or switch change
// R17: flags latch until cleared unless latch disable makes them live
// R18: error sensors filtered by suppression delay from register 11
// R19: error signals suppressed while buffer is active
// R20: buffer timer counts device clock and restarts on a new trigger
//
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "agb_consts.svh"
`default_nettype none
module agb_ctrl #(
    parameter int SW_N = 12,
    parameter int BUF_UNIT = `AGB_BUF_UNIT
)(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Clock pins
    input wire logic ext_clk_in,
    output logic chopper_clk,
    // Buffer trigger and switch drive
    input wire logic buffer_trigger_input,
    output logic buffer_active_flag,
    output logic buffered_main_switch_one,
    output logic buffered_main_switch_two,
    output logic buffered_alt_switch_one,
    output logic buffered_alt_switch_two,
    output logic [SW_N-1:0] switch_ctl,
    // Analog settings
    output logic [3:0] gain_code,
    output logic [2:0] mux_addr,
    output logic out_factor_sel,
    // Raw error sensors and error flag outputs
    input wire agb_pkg::agb_err_s err_sense,
    output agb_pkg::agb_err_s err_flags
);

    // ************************************************************
    // Register storage
    // ************************************************************
    logic [3:0] gain_ff;
    logic [2:0] mux_ff;
    logic osf_ff;
    logic [SW_N-1:0] sw_ff;
    logic extclk_ff;
    logic [7:0] buffer_hold_time_ff;
    logic [7:0] supp_ff;
    logic ltd_ff;
    logic nosupp_ff;
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic [4:0] err_clr;
    logic cmd_start;
    logic wr_go;
    logic rd_go;
    logic [4:0] live_err;
    logic [4:0] err_ff;
    // One wait cycle per access: a write acts at the edge that sees ack_ff set
    assign wr_go = avs_write && ack_ff;
    // Read data is loaded a cycle early so it already stands at the answer edge
    assign rd_go = avs_read && !ack_ff;
    // Acknowledge is set for the single cycle after a request is first seen
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            ack_ff <= 1'b0;
        else
            ack_ff <= (avs_read || avs_write) && !ack_ff;
    end
    // Waitrequest high until the answer edge
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= !((avs_read || avs_write) && !ack_ff);
    end
    // Gain and multiplexer byte, with output stage factor bit
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            gain_ff <= `AGB_GAIN_RST; // R6
            mux_ff <= `AGB_MUX_RST;
            osf_ff <= 1'b0; // R8
        end
        else if (wr_go && avs_address == `AGB_ADDR_GAIN && avs_byteenable[0])
        begin
            // Out-of-range codes are ignored so the gain never leaves the table
            if (avs_writedata[`AGB_GAIN_LSB +: `AGB_GAIN_W] <= `AGB_GAIN_MAX)
                gain_ff <= avs_writedata[`AGB_GAIN_LSB +: `AGB_GAIN_W]; // R4 R5
            mux_ff <= avs_writedata[`AGB_MUX_W-1:0]; // R4
            osf_ff <= avs_writedata[`AGB_OSF_BIT]; // R7
        end
    end
    // Input switch bits, one per switch
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            sw_ff <= `AGB_SW_RST;
        else if (wr_go && avs_address == `AGB_ADDR_SW)
            sw_ff <= avs_writedata[SW_N-1:0]; // R1
    end
    // Clock select, buffer time, suppression delay, configuration
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            extclk_ff <= 1'b0;
            buffer_hold_time_ff <= `AGB_BUFFER_HOLD_TIME_RST;
            supp_ff <= `AGB_SUPP_RST;
            ltd_ff <= 1'b0;
            nosupp_ff <= 1'b0;
        end
        else if (wr_go && avs_byteenable[0])
        begin
            if (avs_address == `AGB_ADDR_CLK)
                extclk_ff <= avs_writedata[`AGB_EXTCLK_BIT]; // R3
            else if (avs_address == `AGB_ADDR_BUFFER_HOLD_TIME)
                buffer_hold_time_ff <= avs_writedata[7:0]; // R9
            else if (avs_address == `AGB_ADDR_SUPP)
                supp_ff <= avs_writedata[7:0]; // R18
            else if (avs_address == `AGB_ADDR_CFG)
            begin
                ltd_ff <= avs_writedata[`AGB_LTD_BIT];
                nosupp_ff <= avs_writedata[`AGB_NOSUPP_BIT];
            end
        end
    end
    // Command byte strobe and write-one-to-clear of error flags
    assign cmd_start = wr_go && avs_address == `AGB_ADDR_CMD
        && avs_writedata[`AGB_CMD_BUF_BIT]; // R10
    assign err_clr = (wr_go && avs_address == `AGB_ADDR_ERR) ? avs_writedata[4:0] : 5'h00;

    // ************************************************************
    // Device clock and chopper clock
    // ************************************************************
    logic [4:0] int_cnt_ff;
    logic int_tick_ff;
    logic ext_d_ff;
    logic ext_tick;
    logic dev_tick;
    logic [1:0] chop_cnt_ff;
    // Internal 1 MHz tick from the system clock
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            int_cnt_ff <= 5'h00;
            int_tick_ff <= 1'b0;
        end
        else if (int_cnt_ff == 5'(`AGB_INT_DIV - 1))
        begin
            int_cnt_ff <= 5'h00;
            int_tick_ff <= 1'b1;
        end
        else
        begin
            int_cnt_ff <= int_cnt_ff + 5'h01;
            int_tick_ff <= 1'b0;
        end
    end
    // External clock rising edge; pin is taken as synchronous
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            ext_d_ff <= 1'b0;
        else
            ext_d_ff <= ext_clk_in;
    end
    assign ext_tick = ext_clk_in && !ext_d_ff;
    assign dev_tick = extclk_ff ? ext_tick : int_tick_ff; // R3
    // Chopper clock toggles every other device tick: 1 MHz / 4
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            chop_cnt_ff <= 2'h0;
            chopper_clk <= 1'b0;
        end
        else if (dev_tick)
        begin
            chop_cnt_ff <= chop_cnt_ff + 2'h1;
            if (chop_cnt_ff[0])
                chopper_clk <= !chopper_clk; // R3
        end
    end

    // ************************************************************
    // Current buffer engine
    // ************************************************************
    agb_pkg::agb_buf_e buf_st_ff;
    logic [15:0] buf_cnt_ff;
    logic trig_d_ff;
    logic buf_start;

    // Trigger pin edge or command bit starts the buffer
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            trig_d_ff <= 1'b0;
        else
            trig_d_ff <= buffer_trigger_input;
    end
    assign buf_start = cmd_start || (buffer_trigger_input && !trig_d_ff); // R10 R11
    // Buffer state and duration timer in device clock ticks
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            buf_st_ff <= agb_pkg::AGB_BUF_IDLE;
            buf_cnt_ff <= 16'h0000;
        end
        else if (buf_start)
        begin
            // A new trigger restarts the full duration
            buf_st_ff <= agb_pkg::AGB_BUF_RUN; // R20
            buf_cnt_ff <= 16'((buffer_hold_time_ff + 9'h001) * BUF_UNIT);
        end
        else
        begin
            case (buf_st_ff)
                agb_pkg::AGB_BUF_IDLE:
                    buf_cnt_ff <= 16'h0000;
                agb_pkg::AGB_BUF_RUN:
                    if (dev_tick)
                    begin
                        if (buf_cnt_ff == 16'h0001)
                            buf_st_ff <= agb_pkg::AGB_BUF_IDLE; // R9
                        buf_cnt_ff <= buf_cnt_ff - 16'h0001; // R20
                    end
                default:
                    buf_st_ff <= agb_pkg::AGB_BUF_IDLE;
            endcase
        end
    end
    // Status and buffer path switches follow the buffer state
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            buffer_active_flag <= 1'b0;
            buffered_main_switch_one <= 1'b0;
            buffered_main_switch_two <= 1'b0;
            buffered_alt_switch_one <= 1'b0;
            buffered_alt_switch_two <= 1'b0;
        end
        else
        begin
            buffer_active_flag <= buf_start || buf_st_ff == agb_pkg::AGB_BUF_RUN; // R12
            buffered_main_switch_one <= buf_start || buf_st_ff == agb_pkg::AGB_BUF_RUN; // R2
            buffered_main_switch_two <= buf_start || buf_st_ff == agb_pkg::AGB_BUF_RUN; // R2
            buffered_alt_switch_one <= buf_start || buf_st_ff == agb_pkg::AGB_BUF_RUN; // R2
            buffered_alt_switch_two <= buf_start || buf_st_ff == agb_pkg::AGB_BUF_RUN; // R2
        end
    end

    // ************************************************************
    // Error filtering and flags
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++)
        begin : g_err
            logic [7:0] flt_ff;
            logic sense;
            assign sense = err_sense[gi] && (nosupp_ff || !buffer_active_flag); // R19
            // Sensor must stay high for the suppression delay in device ticks
            always_ff @(posedge sys_clk)
            begin
                if (rst || !sense)
                    flt_ff <= 8'h00;
                else if (dev_tick && flt_ff != supp_ff)
                    flt_ff <= flt_ff + 8'h01; // R18
            end
            assign live_err[gi] = sense && flt_ff == supp_ff; // R18
            // Set wins over a clear in the same cycle
            always_ff @(posedge sys_clk)
            begin
                if (rst)
                    err_ff[gi] <= 1'b0;
                else if (ltd_ff)
                    err_ff[gi] <= live_err[gi]; // R17
                else if (live_err[gi])
                    err_ff[gi] <= 1'b1; // R13 R14 R15
                else if (err_clr[gi])
                    err_ff[gi] <= 1'b0; // R17
            end
        end
    endgenerate
    assign err_flags = err_ff;

    // ************************************************************
    // Read data and settings outputs
    // ************************************************************
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            rdata_ff <= 32'h00000000;
        else if (rd_go)
        begin
            if (avs_address == `AGB_ADDR_GAIN)
                rdata_ff <= {24'h000000, osf_ff, gain_ff, mux_ff};
            else if (avs_address == `AGB_ADDR_SW)
                rdata_ff <= 32'(sw_ff);
            else if (avs_address == `AGB_ADDR_CLK)
                rdata_ff <= {31'h00000000, extclk_ff};
            else if (avs_address == `AGB_ADDR_BUFFER_HOLD_TIME)
                rdata_ff <= {24'h000000, buffer_hold_time_ff};
            else if (avs_address == `AGB_ADDR_ERR)
                rdata_ff <= {26'h0000000, buffer_active_flag, err_ff};
            else if (avs_address == `AGB_ADDR_CFG)
                rdata_ff <= {30'h00000000, nosupp_ff, ltd_ff};
            else if (avs_address == `AGB_ADDR_CMD)
                rdata_ff <= {26'h0000000, buffer_active_flag, 5'h00}; // R12
            else if (avs_address == `AGB_ADDR_SUPP)
                rdata_ff <= {24'h000000, supp_ff};
            else
                rdata_ff <= 32'h00000000;
        end
    end
    assign avs_readdata = rdata_ff;
    // Settings driven to the analog section
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            gain_code <= `AGB_GAIN_RST;
            mux_addr <= `AGB_MUX_RST;
            out_factor_sel <= 1'b0;
            switch_ctl <= `AGB_SW_RST;
        end
        else
        begin
            gain_code <= gain_ff; // R5
            mux_addr <= mux_ff;
            out_factor_sel <= osf_ff; // R7
            switch_ctl <= sw_ff; // R1
        end
    end

endmodule
`default_nettype wire

// ### common/agb_consts.svh
// Constants for the amplifier gain and buffer control block
`ifndef AGB_CONSTS_SVH
`define AGB_CONSTS_SVH
// Register byte addresses
`define AGB_ADDR_GAIN 6'h00
`define AGB_ADDR_SW 6'h04
`define AGB_ADDR_CLK 6'h08
`define AGB_ADDR_BUFFER_HOLD_TIME 6'h0C
`define AGB_ADDR_ERR 6'h10
`define AGB_ADDR_CFG 6'h14
`define AGB_ADDR_CMD 6'h18
`define AGB_ADDR_SUPP 6'h2C
// Field positions and widths
`define AGB_GAIN_LSB 3
`define AGB_GAIN_W 4
`define AGB_MUX_W 3
`define AGB_CMD_BUF_BIT 5
`define AGB_OSF_BIT 7
`define AGB_EXTCLK_BIT 0
`define AGB_LTD_BIT 0
`define AGB_NOSUPP_BIT 1
`define AGB_BUFFER_ACTIVE_FLAG_BIT 5
// Reset values
`define AGB_GAIN_RST 4'hA
`define AGB_MUX_RST 3'h0
`define AGB_BUFFER_HOLD_TIME_RST 8'h0F
`define AGB_SUPP_RST 8'h04
`define AGB_SW_RST 12'h000
// Highest legal gain code (1/8 attenuation)
`define AGB_GAIN_MAX 4'hA
// Clock figures
`define AGB_SYS_HZ 20000000
`define AGB_INT_HZ 1000000
`define AGB_CHOP_HZ 250000
`define AGB_INT_DIV (`AGB_SYS_HZ / `AGB_INT_HZ)
`define AGB_CHOP_DIV (`AGB_INT_HZ / `AGB_CHOP_HZ)
// Buffer time unit: device clock ticks per field step
`define AGB_BUF_UNIT 8
`endif

// ### common/agb_pkg.sv
// Types for the amplifier gain and buffer control block
package agb_pkg;
    typedef struct packed {
        logic output_stage_fault;
        logic clamp_conduction;
        logic gain_overload;
        logic amp_output_clip;
        logic input_overvoltage;
    } agb_err_s;
    typedef enum logic [1:0] {
        AGB_BUF_IDLE,
        AGB_BUF_RUN
    } agb_buf_e;
endpackage

// ### testbench/agb_ctrl_sva.sv
// Concurrent checks on the ports of the gain and buffer control block
`timescale 1ns/1ns
`default_nettype none
module agb_ctrl_sva #(
    parameter int SW_N = 12
)(
    // Clock, reset and register bus
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    // Buffer and switch drive
    input wire logic buffer_trigger_input,
    input wire logic buffer_active_flag,
    input wire logic buffered_main_switch_one,
    input wire logic buffered_main_switch_two,
    input wire logic buffered_alt_switch_one,
    input wire logic buffered_alt_switch_two,
    input wire logic [SW_N-1:0] switch_ctl,
    // Settings and errors
    input wire logic [3:0] gain_code,
    input wire logic [2:0] mux_addr,
    input wire logic out_factor_sel,
    input wire agb_pkg::agb_err_s err_sense,
    input wire agb_pkg::agb_err_s err_flags
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Write accepted at this edge
    wire logic wack = avs_write && !avs_waitrequest;
    // ***************
    // Assertions
    // ***************
    bus_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered after one wait cycle");
    ack_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    reset_state_a: assert property ($fell(rst) |-> gain_code == 4'hA && !out_factor_sel
        && !buffer_active_flag && err_flags == 5'h00) else $error("bad state after reset");
    // Settings register at the edge that accepts the write, and the outputs copy them a cycle later
    gain_write_a: assert property (wack && avs_address == 6'h00 && avs_byteenable[0]
        && avs_writedata[6:3] <= 4'hA |-> ##2 gain_code == $past(avs_writedata[6:3], 2)
        && mux_addr == $past(avs_writedata[2:0], 2)
        && out_factor_sel == $past(avs_writedata[7], 2))
        else $error("gain byte not applied");
    gain_legal_a: assert property (gain_code <= 4'hA) else $error("gain code out of range");
    switch_write_a: assert property (wack && avs_address == 6'h04
        |-> ##2 switch_ctl == $past(avs_writedata[SW_N-1:0], 2))
        else $error("switch bits not applied");
    switch_follow_a: assert property ({buffered_main_switch_one, buffered_main_switch_two,
        buffered_alt_switch_one, buffered_alt_switch_two} == {4{buffer_active_flag}})
        else $error("buffer path switches differ from buffer state");
    cmd_start_a: assert property (wack && avs_address == 6'h18 && avs_writedata[5]
        |-> ##[1:2] buffer_active_flag) else $error("command did not start buffer");
    trig_start_a: assert property ($rose(buffer_trigger_input)
        |-> ##[1:3] buffer_active_flag) else $error("trigger did not start buffer");
    flag_cause_a: assert property (((err_flags & ~$past(err_flags))
        & ~($past(err_sense) | $past(err_sense, 2))) == 5'h00)
        else $error("flag set without sensor");
endmodule
`default_nettype wire

// ### testbench/agb_host_model.sv
// Host-side register bus master model
`timescale 1ns/1ns
`default_nettype none
module agb_host_model (
    // Clock and slave answer
    input wire logic sys_clk,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Requests
    output logic [5:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic [3:0] avs_byteenable
);
    int tmo = 0;
    // Idle bus from time zero
    initial
    begin
        avs_address = 6'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
    end
    // One transfer, held until waitrequest is seen low; a bound stops a dead slave hanging us
    task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int i;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        q = 32'hFFFFFFFF;
        for (i = 0; i < 16; i++)
        begin
            @(posedge sys_clk);
            if (avs_waitrequest === 1'b0)
                break;
        end
        if (i == 16)
            tmo++;
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        avs_writedata <= ~d;
    endtask
endmodule
`default_nettype wire

// ### testbench/amp_gain_buffer_control_tb.sv
// Self-checking bench for the gain, switch, buffer and error control block
`timescale 1ns/1ns
`default_nettype none
module amp_gain_buffer_control_tb;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic ext_clk_in = 1'b0;
    logic buffer_trigger_input = 1'b0;
    agb_pkg::agb_err_s err_sense = 5'h00;
    agb_pkg::agb_err_s err_flags;
    logic [5:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable, gain_code, bsw;
    logic [2:0] mux_addr;
    logic [11:0] switch_ctl;
    logic avs_read, avs_write, avs_waitrequest, chopper_clk, buffer_active_flag, out_factor_sel;
    int n_fail = 0;
    int cmp_count = 0;
    int ecnt = 0;
    int n;
    // ***************
    // Design, host model, clocks
    // ***************
    agb_ctrl #(.SW_N(12), .BUF_UNIT(1)) i_dut (.sys_clk(sys_clk), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ext_clk_in(ext_clk_in), .chopper_clk(chopper_clk),
        .buffer_trigger_input(buffer_trigger_input), .buffer_active_flag(buffer_active_flag),
        .buffered_main_switch_one(bsw[0]), .buffered_main_switch_two(bsw[1]),
        .buffered_alt_switch_one(bsw[2]), .buffered_alt_switch_two(bsw[3]),
        .switch_ctl(switch_ctl), .gain_code(gain_code), .mux_addr(mux_addr),
        .out_factor_sel(out_factor_sel), .err_sense(err_sense), .err_flags(err_flags));
    agb_host_model i_host (.sys_clk(sys_clk), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable));
    // 20 MHz system clock
    initial
    begin
        forever #25 sys_clk = ~sys_clk;
    end
    // External device clock, period of ten system cycles, unrelated to the internal tick
    always @(posedge sys_clk)
    begin
        ecnt <= (ecnt == 4) ? 0 : ecnt + 1;
        if (ecnt == 4)
            ext_clk_in <= !ext_clk_in;
    end
    // Watchdog against a hang
    initial
    begin
        #5000000;
        n_fail++;
        wrap_up();
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
            n_fail++;
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        i_host.xfer(1'b1, a, d, q);
        if (i_host.tmo != 0)
            wrap_up();
    endtask
    // Read and compare the masked word
    task automatic rdc(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        i_host.xfer(1'b0, a, 32'h0, q);
        check(q & m, e);
        if (i_host.tmo != 0)
            wrap_up();
    endtask
    // Chopper rising edges in k cycles
    task automatic chop(input int k, input int e);
        int c;
        logic p;
        c = 0;
        p = chopper_clk;
        repeat (k)
        begin
            @(posedge sys_clk);
            c += (chopper_clk && !p) ? 1 : 0;
            p = chopper_clk;
        end
        check(32'(c), 32'(e));
    endtask
    // Trigger pulse, then cycles until the buffer drops; 4 ticks of 20 cycles expected
    task automatic trig_len(input int gap);
        buffer_trigger_input <= 1'b1;
        cyc(2);
        buffer_trigger_input <= 1'b0;
        cyc(gap);
        n = 0;
        while (buffer_active_flag !== 1'b0 && n < 300)
        begin
            @(posedge sys_clk);
            n++;
        end
        check(32'(n >= 56 && n <= 84), 32'h1);
    endtask
    task automatic wrap_up();
        n_fail += i_host.tmo;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ***************
    // Main sequence
    // ***************
    initial
    begin
        cyc(8);
        rst <= 1'b0;
        rdc(6'h00, 32'hFF, 32'h50);
        rdc(6'h10, 32'h3F, 32'h0);
        rdc(6'h3C, 32'hFFFFFFFF, 32'h0);
        for (int g = 0; g <= 10; g++)
        begin
            wr(6'h00, {24'h0, g[0], g[3:0], g[2:0]});
            cyc(2);
            check({gain_code, mux_addr, out_factor_sel}, {g[3:0], g[2:0], g[0]});
        end
        wr(6'h00, 32'h5B);
        cyc(2);
        check({gain_code, mux_addr}, {4'hA, 3'h3});
        for (int i = 0; i < 12; i++)
        begin
            wr(6'h04, 32'h1 << i);
            cyc(2);
            check(32'(switch_ctl), 32'h1 << i);
        end
        chop(800, 10);
        wr(6'h08, 32'h1);
        cyc(40);
        chop(800, 20);
        wr(6'h08, 32'h0);
        wr(6'h0C, 32'h3);
        wr(6'h00, 32'h50);
        wr(6'h18, 32'h20);
        rdc(6'h10, 32'h20, 32'h20);
        rdc(6'h18, 32'h20, 32'h20);
        check(32'(bsw), 32'hF);
        cyc(100);
        rdc(6'h18, 32'h20, 32'h0);
        check(32'(bsw), 32'h0);
        trig_len(0);
        buffer_trigger_input <= 1'b1;
        cyc(2);
        buffer_trigger_input <= 1'b0;
        cyc(40);
        trig_len(0);
        wr(6'h2C, 32'h1);
        for (int i = 0; i < 5; i++)
        begin
            err_sense <= 5'h01 << i;
            cyc(60);
            err_sense <= 5'h00;
            cyc(5);
            check(32'(err_flags), 32'h1 << i);
            rdc(6'h10, 32'h1F, 32'h1 << i);
            wr(6'h10, 32'h1 << i);
            cyc(1);
            check(32'(err_flags), 32'h0);
        end
        wr(6'h18, 32'h20);
        cyc(4);
        err_sense <= 5'h1F;
        cyc(40);
        err_sense <= 5'h00;
        cyc(60);
        check(32'(err_flags), 32'h0);
        wr(6'h2C, 32'h4);
        err_sense <= 5'h04;
        cyc(30);
        err_sense <= 5'h00;
        cyc(10);
        check(32'(err_flags), 32'h0);
        wr(6'h2C, 32'h1);
        wr(6'h14, 32'h1);
        err_sense <= 5'h02;
        cyc(60);
        check(32'(err_flags), 32'h2);
        err_sense <= 5'h00;
        cyc(60);
        check(32'(err_flags), 32'h0);
        wrap_up();
    end
endmodule
bind agb_ctrl agb_ctrl_sva #(.SW_N(SW_N)) i_sva (.sys_clk(sys_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_waitrequest(avs_waitrequest), .buffer_trigger_input(buffer_trigger_input),
    .buffer_active_flag(buffer_active_flag), .buffered_main_switch_one(buffered_main_switch_one),
    .buffered_main_switch_two(buffered_main_switch_two),
    .buffered_alt_switch_one(buffered_alt_switch_one),
    .buffered_alt_switch_two(buffered_alt_switch_two), .switch_ctl(switch_ctl),
    .gain_code(gain_code), .mux_addr(mux_addr), .out_factor_sel(out_factor_sel),
    .err_sense(err_sense), .err_flags(err_flags));
`default_nettype wire
